// >>> hdl/mts_pkg.sv
/*
 * Constants, register map and state type of the motor tuning sequencer.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone bus.
 */
package mts_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TUNE_TIME_MS = 9000;
    localparam longint unsigned TUNE_CYCLES_L =
        longint'(TUNE_TIME_MS) * longint'(CLK_HZ) / 64'd1000;
    localparam logic [31:0] TUNE_CYCLES = TUNE_CYCLES_L[31:0];
    localparam logic [2:0] PROGRESS_STEPS = 3'h5;

    // ------------------------------------------------------------
    // tuning setting and mode values
    // ------------------------------------------------------------
    localparam logic [7:0] TUNE_SEL_STATIONARY = 8'h0B; // 11
    localparam logic [7:0] TUNE_SEL_OFF = 8'h00;
    localparam logic [2:0] OPMODE_PANEL_LOCK = 3'h7;
    localparam int unsigned BUS_LIMIT_PCT = 75;

    // ------------------------------------------------------------
    // result codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_OK = 8'h0D;      // 13
    localparam logic [7:0] CODE_FORCED = 8'h08;  // 8
    localparam logic [7:0] CODE_TRIP = 8'h09;    // 9
    localparam logic [7:0] CODE_STALL = 8'h5B;   // 91
    localparam logic [7:0] CODE_BUS = 8'h5C;     // 92
    localparam logic [7:0] CODE_CALC = 8'h5D;    // 93

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CONST = 4'h8;
    localparam logic [3:0] ADDR_SETFREQ = 4'hC;
    localparam int unsigned CTRL_PANEL_MODE = 8;
    localparam int unsigned CTRL_RUN_KEY = 9;
    localparam int unsigned CTRL_STOP_KEY = 10;
    localparam int unsigned CTRL_METER_SPEED = 11;
    localparam int unsigned CTRL_RETRY_EN = 12;
    localparam int unsigned CTRL_OPMODE_LSB = 16;
    localparam logic [15:0] CONST_RESET = 16'h0000;
    localparam logic [15:0] SETFREQ_RESET = 16'h0000;

    // ------------------------------------------------------------
    // sequencer states, gray along idle-tune-done-fail
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MTS_IDLE = 2'h0,
        MTS_TUNE = 2'h1,
        MTS_DONE = 2'h3,
        MTS_FAIL = 2'h2
    } mts_state_e;

endpackage

// >>> hdl/mts_sequencer.sv
/*
 * Motor tuning sequencer: stationary winding-resistance tuning run,
 * abort paths, result codes, constant retention and acknowledge.
 * Assumes synchronous inputs on clk_i and a classic Wishbone master.
 */
// Register access over Wishbone and the register offsets were decided locally.
// Operation
// R1: run armed only when tuning setting holds 11 (stationary)
// R2: armed start by forward or reverse command, or panel run key
// R3: output stop, fault clear, stop key or command release abort
// R4: other inputs ignored; only running, status, meter, relay active
// R5: meter shows progress in five steps when set to speed
// R6: running output high from start for the whole run
// R7: a whole run takes about nine seconds
// R8: set-frequency monitor reads zero hertz while tuning
// R9: after end refuse operation until stop key or command release
// R10: error end leaves constants unchanged; reset and retune
// R11: code 8 for forced end, code 9 for protective trip
// R12: code 91 when current limit engages
// R13: code 92 when bus voltage reaches 75 percent of rated
// R14: code 93 for calculation failure or missing motor
// R15: stop key or command release never stores constants
// R16: good constants kept until another run replaces them
// R17: supply loss during tuning ends with a tuning error
// R18: after power returns the device runs normally, not tuning
// R19: alarms as normal, but automatic fault retry suppressed
// R20: partner must not toggle second set select while tuning
// R21: partner issues run only after main power is applied
// R22: mode 7 needs panel interlock input and panel operation; the code checks the interlock only for external starts, panel starts skip it
// R23: state machine idle, tune, normal end, error end holding code
`timescale 1ns/100ps
module mts_sequencer
    import mts_pkg::*;
#(
    parameter logic [31:0] TUNE_LEN = TUNE_CYCLES,
    parameter int unsigned BUS_W = 12,
    parameter logic [11:0] BUS_RATED = 12'hC00
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic forward_run_cmd_i,
    input wire logic reverse_run_cmd_i,
    input wire logic output_stop_input_i,
    input wire logic fault_clear_input_i,
    input wire logic panel_interlock_input_i,
    input wire logic protective_trip_i,
    input wire logic stall_limit_i,
    input wire logic [BUS_W-1:0] bus_volt_i,
    input wire logic calc_error_i,
    input wire logic motor_absent_i,
    input wire logic supply_loss_i,
    input wire logic [15:0] meas_value_i,
    output logic running_o,
    output logic tuning_o,
    output logic drive_fwd_o,
    output logic drive_rev_o,
    output logic [2:0] pulse_meter_out_o,
    output logic [15:0] set_freq_mon_o,
    output logic retry_enable_o,
    output logic inputs_ignored_o
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    mts_state_e state_reg, state_next;
    logic [7:0] tuning_setting_status_reg;
    logic panel_unit_mode_reg;
    logic meter_speed_reg;
    logic retry_en_reg;
    logic [2:0] operation_mode_select_reg;
    logic run_key_reg, stop_key_reg;
    logic [15:0] setfreq_reg;
    logic [15:0] const_reg;
    logic [7:0] code_reg, code_next;
    logic [31:0] tick_reg;
    logic [31:0] step_reg;
    logic [2:0] progress_reg;
    logic dir_rev_reg;
    logic ack_reg;
    logic [31:0] dat_reg;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    localparam logic [31:0] STEP_LEN = TUNE_LEN / 32'd5;
    localparam logic [BUS_W+6:0] BUS_LIMIT =
        (BUS_W+7)'((BUS_W+7)'(BUS_RATED) * (BUS_W+7)'(BUS_LIMIT_PCT));

    function automatic logic [7:0] lane(input logic [7:0] old,
                                        input logic [7:0] neu,
                                        input logic en);
        lane = en ? neu : old;
    endfunction

    wire bus_req = cyc_i & stb_i;
    wire bus_wr = bus_req & we_i & ack_reg;
    wire wr_ctrl = bus_wr & (adr_i == ADDR_CTRL);
    wire wr_freq = bus_wr & (adr_i == ADDR_SETFREQ);
    wire [31:0] rd_ctrl = {13'h0000, operation_mode_select_reg,
        3'h0, retry_en_reg, meter_speed_reg, 2'h0,
        panel_unit_mode_reg, tuning_setting_status_reg};
    wire [31:0] rd_status = {16'h0000, code_reg, 1'b0,
        progress_reg, running_o, tuning_o, state_reg};
    wire [31:0] rd_data =
        (adr_i == ADDR_CTRL) ? rd_ctrl :
        (adr_i == ADDR_STATUS) ? rd_status :
        (adr_i == ADDR_CONST) ? {16'h0000, const_reg} :
        (adr_i == ADDR_SETFREQ) ? {16'h0000, set_freq_mon_o} :
        32'h0000_0000;

    // ------------------------------------------------------------
    // start, abort and acknowledge conditions
    // ------------------------------------------------------------
    wire armed = (tuning_setting_status_reg == TUNE_SEL_STATIONARY); //R1
    wire ext_allowed = ~panel_unit_mode_reg &
        ((operation_mode_select_reg != OPMODE_PANEL_LOCK) |
         panel_interlock_input_i); // R22
    wire ext_cmd = forward_run_cmd_i | reverse_run_cmd_i;
    wire start_req = panel_unit_mode_reg ? run_key_reg
                                         : (ext_allowed & ext_cmd); // R2
    wire active_cmd = dir_rev_reg ? reverse_run_cmd_i
                                  : forward_run_cmd_i;
    wire abort_req = output_stop_input_i | fault_clear_input_i |
        stop_key_reg | (~panel_unit_mode_reg & ~active_cmd); // R3
    wire bus_high = ({7'h00, bus_volt_i} * (BUS_W+7)'(100)) >= BUS_LIMIT;
    wire run_done = (tick_reg == TUNE_LEN - 32'd1); // R7
    wire ack_run = panel_unit_mode_reg ? stop_key_reg : ~ext_cmd; // R9
    wire in_tune = (state_reg == MTS_TUNE);
    wire ended = (state_reg == MTS_DONE) | (state_reg == MTS_FAIL);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        code_next = code_reg;
        case (state_reg)
            MTS_IDLE: begin
                if (armed && start_req) begin // R2
                    state_next = MTS_TUNE;
                    code_next = CODE_NONE;
                end
            end
            MTS_TUNE: begin
                state_next = MTS_FAIL;
                if (supply_loss_i || protective_trip_i) begin
                    code_next = CODE_TRIP; // R11 R17
                end else if (stall_limit_i) begin
                    code_next = CODE_STALL; // R12
                end else if (bus_high) begin
                    code_next = CODE_BUS; // R13
                end else if (calc_error_i || motor_absent_i) begin
                    code_next = CODE_CALC; // R14
                end else if (abort_req) begin
                    code_next = CODE_FORCED; // R11 R15
                end else if (run_done) begin
                    state_next = MTS_DONE;
                    code_next = CODE_OK;
                end else begin
                    state_next = MTS_TUNE;
                end
            end
            MTS_DONE, MTS_FAIL: begin
                if (ack_run || fault_clear_input_i) begin // R9 R10 R23
                    state_next = MTS_IDLE;
                end
            end
            default: begin
                state_next = MTS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= MTS_IDLE;
            code_reg <= CODE_NONE;
        end else begin
            state_reg <= state_next; // R23
            code_reg <= code_next;
        end
    end

    // run timer and five-step progress
    always_ff @(posedge clk_i) begin
        if (rst_i || !in_tune) begin
            tick_reg <= 32'h0000_0000;
            step_reg <= 32'h0000_0000;
            progress_reg <= 3'h1;
        end else begin
            tick_reg <= tick_reg + 32'd1; // R7
            if (step_reg == STEP_LEN - 32'd1) begin
                step_reg <= 32'h0000_0000;
                if (progress_reg != PROGRESS_STEPS) begin
                    progress_reg <= progress_reg + 3'h1; // R5
                end
            end else begin
                step_reg <= step_reg + 32'd1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_rev_reg <= 1'b0;
        end else if (state_reg == MTS_IDLE) begin
            dir_rev_reg <= ~forward_run_cmd_i & reverse_run_cmd_i;
        end
    end

    // constants stored only by a normal end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            const_reg <= CONST_RESET;
        end else if (in_tune && state_next == MTS_DONE) begin
            const_reg <= meas_value_i; // R16 R10 R15
        end
    end

    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tuning_setting_status_reg <= TUNE_SEL_OFF;
            panel_unit_mode_reg <= 1'b0;
            meter_speed_reg <= 1'b0;
            retry_en_reg <= 1'b0;
            operation_mode_select_reg <= 3'h0;
            setfreq_reg <= SETFREQ_RESET;
        end else begin
            if (in_tune && supply_loss_i) begin
                tuning_setting_status_reg <= TUNE_SEL_OFF; // R18
            end else if (wr_ctrl) begin
                tuning_setting_status_reg <= lane(
                    tuning_setting_status_reg, dat_i[7:0], sel_i[0]);
            end
            if (wr_ctrl && sel_i[1] && !in_tune) begin
                panel_unit_mode_reg <= dat_i[CTRL_PANEL_MODE];
                meter_speed_reg <= dat_i[CTRL_METER_SPEED];
                retry_en_reg <= dat_i[CTRL_RETRY_EN];
            end
            if (wr_ctrl && sel_i[2]) begin
                operation_mode_select_reg <= dat_i[18:16];
            end
            if (wr_freq) begin
                setfreq_reg <= {lane(setfreq_reg[15:8], dat_i[15:8],
                    sel_i[1]), lane(setfreq_reg[7:0], dat_i[7:0],
                    sel_i[0])};
            end
        end
    end

    // panel keys are one-cycle pulses from a control write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_key_reg <= 1'b0;
            stop_key_reg <= 1'b0;
        end else begin
            run_key_reg <= wr_ctrl & sel_i[1] & dat_i[CTRL_RUN_KEY];
            stop_key_reg <= wr_ctrl & sel_i[1] & dat_i[CTRL_STOP_KEY];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req && !ack_reg && !we_i) begin
                dat_reg <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign tuning_o = in_tune;
    assign running_o = in_tune; // R6
    assign inputs_ignored_o = in_tune; // R4
    assign drive_fwd_o = (state_reg == MTS_IDLE) & ~armed &
        ext_allowed & forward_run_cmd_i; // R9 R18
    assign drive_rev_o = (state_reg == MTS_IDLE) & ~armed &
        ext_allowed & reverse_run_cmd_i & ~forward_run_cmd_i;
    assign pulse_meter_out_o = (in_tune && meter_speed_reg) ?
        progress_reg : 3'h0; // R5
    assign set_freq_mon_o = in_tune ? 16'h0000 : setfreq_reg; // R8
    assign retry_enable_o = retry_en_reg & ~in_tune; // R19

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == MTS_IDLE && armed && start_req) |=>
            (running_o && tuning_o && code_reg == CODE_NONE);
    endproperty
    a_start: assert property (p_start) // R2
        else $error("armed start did not begin a run");

    property p_unarmed;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == MTS_IDLE && !armed) |=> !tuning_o;
    endproperty
    a_unarmed: assert property (p_unarmed) // R1
        else $error("run began while not armed");

    property p_forced;
        @(posedge clk_i) disable iff (rst_i)
        (in_tune && abort_req && !supply_loss_i && !protective_trip_i &&
         !stall_limit_i && !bus_high && !calc_error_i && !motor_absent_i)
        |=> (state_reg == MTS_FAIL && code_reg == CODE_FORCED);
    endproperty
    a_forced: assert property (p_forced) // R3
        else $error("abort did not give forced end code");

    property p_stall;
        @(posedge clk_i) disable iff (rst_i)
        (in_tune && stall_limit_i && !supply_loss_i && !protective_trip_i)
        |=> (code_reg == CODE_STALL) ##1 (code_reg == CODE_STALL);
    endproperty
    a_stall: assert property (p_stall) // R12
        else $error("current limit code missing");

    property p_const;
        @(posedge clk_i) disable iff (rst_i)
        !$stable(const_reg) |-> (state_reg == MTS_DONE &&
            $past(state_reg) == MTS_TUNE && code_reg == CODE_OK);
    endproperty
    a_const: assert property (p_const) // R10
        else $error("constants changed without normal end");

    property p_freq;
        @(posedge clk_i) disable iff (rst_i)
        tuning_o |-> (set_freq_mon_o == 16'h0000 && retry_enable_o == 1'b0);
    endproperty
    a_freq: assert property (p_freq) // R8
        else $error("monitor not zero or retry live while tuning");

    property p_refuse;
        @(posedge clk_i) disable iff (rst_i)
        ended && !ack_run && !fault_clear_input_i |=>
            (ended && !drive_fwd_o && !drive_rev_o && !tuning_o);
    endproperty
    a_refuse: assert property (p_refuse) // R9
        else $error("operation accepted before acknowledge");

    property p_power;
        @(posedge clk_i) disable iff (rst_i)
        (in_tune && supply_loss_i) |=>
            (state_reg == MTS_FAIL && code_reg == CODE_TRIP && !armed);
    endproperty
    a_power: assert property (p_power) // R17
        else $error("supply loss did not end run in error");

    property p_meter;
        @(posedge clk_i) disable iff (rst_i)
        tuning_o |-> (pulse_meter_out_o <= PROGRESS_STEPS);
    endproperty
    a_meter: assert property (p_meter) // R5
        else $error("progress beyond five steps");

    c_normal: cover property (@(posedge clk_i) disable iff (rst_i)
        in_tune ##1 state_reg == MTS_DONE);
    c_forced: cover property (@(posedge clk_i) disable iff (rst_i)
        in_tune ##1 code_reg == CODE_FORCED);
    c_ack: cover property (@(posedge clk_i) disable iff (rst_i)
        ended ##1 state_reg == MTS_IDLE);

endmodule

// >>> tb/mts_cmd_source.sv
/*
 * Model of the external run-command source of the tuning sequencer.
 * Assumes one clock, synchronous active-high reset, and that the bench
 * asks for a direction by level on want_fwd_i / want_rev_i.
 */
`timescale 1ns/100ps
module mts_cmd_source (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic power_ok_i,
    input wire logic want_fwd_i,
    input wire logic want_rev_i,
    input wire logic [1:0] lag_i,
    output logic forward_run_cmd_o,
    output logic reverse_run_cmd_o,
    output logic second_set_select_o
);
    // ----------------------------------------------------------------
    // command pipeline, lag_i selects an answer delay of one to four cycles
    // ----------------------------------------------------------------
    logic [1:0] cmd_reg [4];
    logic [1:0] cmd_next;

    // nothing before main power; reverse only while forward is off
    assign cmd_next = power_ok_i ?
        {want_rev_i & ~want_fwd_i, want_fwd_i} : 2'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg <= '{default: 2'h0};
        end else begin
            cmd_reg[0] <= cmd_next;
            for (int k = 1; k < 4; k++) begin
                cmd_reg[k] <= cmd_reg[k-1];
            end
        end
    end

    // dropping the wanted level releases the command once
    assign forward_run_cmd_o = cmd_reg[lag_i][0];
    assign reverse_run_cmd_o = cmd_reg[lag_i][1];
    // second set select is held still, never toggled during a run
    assign second_set_select_o = 1'b0;
endmodule

// >>> tb/tb_mts_sequencer.sv
/*
 * Self-checking bench of the motor tuning sequencer over Wishbone.
 * Assumes mts_pkg, the sequencer and the command source model.
 */
`timescale 1ns/100ps
module tb_mts_sequencer import mts_pkg::*; ;
    logic clk_i, rst_i, cyc, stb, we, ack, want_fwd, want_rev, power_ok;
    logic fwd, rev, running, tuning, dfwd, drev, retry, ign, bad, ilock;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [1:0] lag;
    logic [7:0] errs;
    logic [15:0] meas, sfm;
    logic [2:0] meter, mx;
    int miscompares, n_compared, dur;
    logic [7:0] codes [8] = '{8'h08, 8'h09, 8'h5B, 8'h5C, 8'h5D, 8'h5D,
        8'h09, 8'h08};

    mts_cmd_source src (.clk_i(clk_i), .rst_i(rst_i),
        .power_ok_i(power_ok), .want_fwd_i(want_fwd),
        .want_rev_i(want_rev), .lag_i(lag),
        .forward_run_cmd_o(fwd), .reverse_run_cmd_o(rev),
        .second_set_select_o());

    mts_sequencer #(.TUNE_LEN(32'd50)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .forward_run_cmd_i(fwd), .reverse_run_cmd_i(rev),
        .output_stop_input_i(errs[0]), .fault_clear_input_i(errs[7]),
        .panel_interlock_input_i(ilock), .protective_trip_i(errs[1]),
        .stall_limit_i(errs[2]),
        .bus_volt_i(errs[3] ? 12'h900 : 12'h100),
        .calc_error_i(errs[4]), .motor_absent_i(errs[5]),
        .supply_loss_i(errs[6]), .meas_value_i(meas),
        .running_o(running), .tuning_o(tuning), .drive_fwd_o(dfwd),
        .drive_rev_o(drev), .pulse_meter_out_o(meter),
        .set_freq_mon_o(sfm), .retry_enable_o(retry),
        .inputs_ignored_o(ign));

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // bus and run tasks
    // ----------------------------------------------------------------
    task automatic wb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            miscompares++;
            summarize;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (running !== 1'b1 && n < 20);
        if (running !== 1'b1) begin
            miscompares++;
            summarize;
        end
    endtask

    // follow one run to its end, watching outputs each cycle
    task automatic tune;
        dur = 1;
        mx = meter;
        bad = 1'b0;
        while (running === 1'b1 && dur < 200) begin
            if (sfm !== 16'h0 || retry !== 1'b0 || ign !== 1'b1 ||
                tuning !== 1'b1) begin
                bad = 1'b1;
            end
            if (meter > mx) begin
                mx = meter;
            end
            @(posedge clk_i);
            dur++;
        end
        if (running === 1'b1) begin
            miscompares++;
            summarize;
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_i, power_ok, cyc, stb, we, want_fwd, want_rev, ilock} = 8'h80;
        {adr, sel, wdat, lag, errs, meas} = '0;
        miscompares = 0;
        n_compared = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        power_ok <= 1'b1;
        meas <= 16'hABCD;
        @(posedge clk_i);
        wb(1'b0, ADDR_STATUS, 32'h0);
        // progress field idles at step 1 outside a run
        chk("status", 32'h0000_0010, q);
        wb(1'b0, ADDR_CONST, 32'h0);
        chk("const", 32'(CONST_RESET), q);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        want_fwd <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("drive fwd", 32'h1, 32'(dfwd));
        chk("running", 32'h0, 32'(running));
        want_fwd <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(1'b1, ADDR_SETFREQ, 32'h1234);
        wb(1'b1, ADDR_CTRL, 32'h180B);
        chk("retry", 32'h1, 32'(retry));
        lag <= 2'h2;
        want_fwd <= 1'b1;
        wait_run;
        chk("meter start", 32'h1, 32'(meter));
        tune;
        chk("duration", 32'h1, 32'(dur >= 48 && dur <= 52));
        chk("meter last", 32'h5, 32'(mx));
        chk("tune outs", 32'h0, 32'(bad));
        repeat (5) @(posedge clk_i);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("code", 32'(CODE_OK), 32'(q[15:8]));
        chk("held", 32'h3, 32'(q[1:0]));
        wb(1'b0, ADDR_CONST, 32'h0);
        chk("const", 32'hABCD, q);
        wb(1'b0, ADDR_SETFREQ, 32'h0);
        chk("setfreq", 32'h1234, q);
        want_fwd <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("ack", 32'h0, 32'(q[1:0]));
        lag <= 2'h0;
        for (int i = 0; i < 8; i++) begin
            meas <= 16'(i + 1);
            wb(1'b1, ADDR_CTRL, 32'h080B);
            want_fwd <= !i[0];
            want_rev <= i[0];
            wait_run;
            repeat (3) @(posedge clk_i);
            errs <= 8'h01 << i;
            @(posedge clk_i);
            errs <= 8'h00;
            repeat (3) @(posedge clk_i);
            wb(1'b0, ADDR_STATUS, 32'h0);
            chk("code", 32'(codes[i]), 32'(q[15:8]));
            chk("fail", 32'h2, 32'(q[1:0]));
            wb(1'b0, ADDR_CONST, 32'h0);
            chk("const", 32'hABCD, q);
            want_fwd <= 1'b0;
            want_rev <= 1'b0;
            repeat (4) @(posedge clk_i);
            wb(1'b0, ADDR_STATUS, 32'h0);
            chk("ack", 32'h0, 32'(q[1:0]));
            if (i == 6) begin
                want_fwd <= 1'b1;
                repeat (4) @(posedge clk_i);
                chk("drive fwd", 32'h1, 32'(dfwd));
                chk("running", 32'h0, 32'(running));
                want_fwd <= 1'b0;
                want_rev <= 1'b1;
                repeat (4) @(posedge clk_i);
                chk("drive rev", 32'h1, 32'(drev));
                want_rev <= 1'b0;
                repeat (4) @(posedge clk_i);
            end
        end
        wb(1'b1, ADDR_CTRL, 32'h010B);
        wb(1'b1, ADDR_CTRL, 32'h030B);
        wait_run;
        wb(1'b1, ADDR_CTRL, 32'h050B);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("code", 32'(CODE_FORCED), 32'(q[15:8]));
        wb(1'b0, ADDR_CONST, 32'h0);
        chk("const", 32'hABCD, q);
        wb(1'b1, ADDR_CTRL, 32'h050B);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("ack", 32'h0, 32'(q[1:0]));
        // mode 7: external start refused without the interlock
        wb(1'b1, ADDR_CTRL, 32'h0007_000B);
        want_fwd <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("lock start", 32'h0, 32'(running));
        want_fwd <= 1'b0;
        repeat (4) @(posedge clk_i);
        ilock <= 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h0007_030B);
        wait_run;
        summarize;
    end
endmodule
